// >>> hw/chpm_pin_map.sv
// Connector pin function map for memory, I/O and task-file modes.
// Assumes host strobes are already synchronous to aclk.
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
// Contract
// R1: Memory and I/O modes decode eleven address lines plus attribute select.
// R2: Task-file mode uses only address bits two to zero, eight registers.
// R3: Host grounds upper address lines in task-file mode.
// R4: Host ties attribute select and write enable high in task-file mode.
// R5: Memory mode drives both battery detect outputs high.
// R6: I/O mode pulls status changed low on ready or protect change, if enabled.
// R7: I/O mode drives audio out; no audio function holds it negated.
// R8: Pass diagnostic is a two-way handshake line in task-file mode.
// R9: Card works with upper data byte unconnected in 8-bit hosts.
// R10: Storage card implements task-file mode; expansion card may omit it.
// R11: Cable select grounded gives master, open gives slave.
// R12: Drive active/slave present is a two-way handshake line in task-file mode.
// R13: Shared pins change function with the active mode.
// R14: Mode is latched at reset and fixed until the next reset.
module chpm_pin_map (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write
  input  wire logic [chpm_pkg::CHPM_AW-1:0] s_awaddr,
  input  wire logic                 s_awvalid,
  output logic                      s_awready,
  input  wire logic [31:0]          s_wdata,
  input  wire logic [3:0]           s_wstrb,
  input  wire logic                 s_wvalid,
  output logic                      s_wready,
  output logic [1:0]                s_bresp,
  output logic                      s_bvalid,
  input  wire logic                 s_bready,
  // AXI4-Lite read
  input  wire logic [chpm_pkg::CHPM_AW-1:0] s_araddr,
  input  wire logic                 s_arvalid,
  output logic                      s_arready,
  output logic [31:0]               s_rdata,
  output logic [1:0]                s_rresp,
  output logic                      s_rvalid,
  input  wire logic                 s_rready,
  // Host address side
  input  wire logic [10:0]          host_addr,
  input  wire logic                 attr_select_n,
  input  wire logic                 cable_select_n,
  // Shared outputs
  output logic                      pin37_o,
  output logic                      pin37_oe,
  output logic                      pin42_o,
  output logic                      pin42_oe,
  output logic                      input_acknowledge_n,
  // Two-way pins 45 and 46
  input  wire logic                 pin45_i,
  output logic                      pin45_o,
  output logic                      pin45_oe,
  input  wire logic                 pin46_i,
  output logic                      pin46_o,
  output logic                      pin46_oe,
  // Decode results
  output logic [10:0]               reg_select,
  output logic                      attr_space,
  output logic                      is_master
);
  import chpm_pkg::*;

  typedef struct packed {
    chpm_mode_t  mode;
    logic        master;
    logic [9:0]  ctrl;
    logic [1:0]  csr;
    logic        ready_d;
    logic        wp_d;
    logic        status_alert;
    logic        far_diag;
    logic        far_active;
    logic [10:0] sel;
    logic        attr;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } chpm_state_t;

  chpm_state_t st_reg;
  chpm_state_t st_next;
  chpm_mode_t  req_mode;
  logic        p45_lvl;
  logic        p46_lvl;
  logic        p45_od;
  logic        p46_od;
  logic        p45_en;
  logic        p46_en;
  logic        do_write;
  logic        do_read;

  // ****************************************
  // Mode request with illegal codes folded
  // ****************************************
  always_comb begin
    unique case (st_reg.ctrl[CHPM_CTRL_MODE_LO +: 2])
      2'h1:    req_mode = CHPM_MODE_IO;
      // R10: storage card offers task file
      2'h2,
      2'h3:    req_mode = CHPM_HAS_IDE ? CHPM_MODE_IDE : CHPM_MODE_MEM;
      default: req_mode = CHPM_MODE_MEM;
    endcase
  end

  assign do_write = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;
  assign do_read  = s_arvalid & ~st_reg.rvalid;

  always_comb begin
    st_next = st_reg;
    // ****************************************
    // Register bus
    // ****************************************
    if (s_awvalid && !st_reg.aw_got) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_awaddr;
    end
    if (s_wvalid && !st_reg.w_got) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_wdata;
      // Strobes travel with their data beat
      st_next.wstrb = s_wstrb;
    end
    if (do_write) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = CHPM_RESP_OKAY;
      unique case (st_reg.awaddr)
        CHPM_OFF_CTRL: begin
          if (st_reg.wstrb[0]) st_next.ctrl[7:0] = st_reg.wdata[7:0];
          if (st_reg.wstrb[1]) st_next.ctrl[9:8] = st_reg.wdata[9:8];
        end
        CHPM_OFF_CSR: begin
          if (st_reg.wstrb[0]) begin
            st_next.csr[CHPM_CSR_SIGCHG] = st_reg.wdata[CHPM_CSR_SIGCHG];
            // Write one clears the change flag
            if (st_reg.wdata[CHPM_CSR_CHANGED]) st_next.csr[CHPM_CSR_CHANGED] = 1'b0;
          end
        end
        CHPM_OFF_STATUS,
        CHPM_OFF_ADDR: ;
        default: st_next.bresp = CHPM_RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_bready) st_next.bvalid = 1'b0;
    if (do_read) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = CHPM_RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      unique case (s_araddr)
        CHPM_OFF_CTRL:   st_next.rdata[9:0] = st_reg.ctrl;
        CHPM_OFF_STATUS: st_next.rdata[5:0] = {st_reg.far_active, st_reg.far_diag,
                                               st_reg.master, st_reg.status_alert,
                                               st_reg.mode};
        CHPM_OFF_CSR:    st_next.rdata[1:0] = st_reg.csr;
        CHPM_OFF_ADDR:   st_next.rdata[11:0] = {st_reg.attr, st_reg.sel};
        default:         st_next.rresp = CHPM_RESP_SLVERR;
      endcase
    end
    if (st_reg.rvalid && s_rready) st_next.rvalid = 1'b0;

    // ****************************************
    // Address decode
    // ****************************************
    if (st_reg.mode == CHPM_MODE_IDE) begin
      // R2: three low bits pick task file register
      st_next.sel  = {8'h00, host_addr[2:0]};
      st_next.attr = 1'b0;
    end else begin
      // R1: full address plus attribute space
      st_next.sel  = host_addr;
      st_next.attr = ~attr_select_n;
    end

    // R6: change of ready or protect sets the change flag; the alert also needs I/O mode and the enable
    st_next.ready_d = st_reg.ctrl[CHPM_CTRL_RDY];
    st_next.wp_d    = st_reg.ctrl[CHPM_CTRL_WP];
    if ((st_reg.ready_d != st_reg.ctrl[CHPM_CTRL_RDY]) ||
        (st_reg.wp_d != st_reg.ctrl[CHPM_CTRL_WP]))
      st_next.csr[CHPM_CSR_CHANGED] = 1'b1;
    st_next.status_alert = (st_reg.mode == CHPM_MODE_IO) & st_reg.csr[CHPM_CSR_SIGCHG]
                           & st_reg.csr[CHPM_CSR_CHANGED];

    // Partner handshake levels, seen only in task-file mode
    st_next.far_diag   = (st_reg.mode == CHPM_MODE_IDE) & ~pin46_i;
    st_next.far_active = (st_reg.mode == CHPM_MODE_IDE) & ~pin45_i;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg      <= '0;
      st_reg.ctrl <= CHPM_CTRL_RST;
      // R14: mode taken at reset from stored request
      st_reg.mode <= req_mode;
      // R11: grounded cable select means master
      st_reg.master <= ~cable_select_n;
      // R6: no false change after reset
      st_reg.ready_d <= CHPM_CTRL_RST[CHPM_CTRL_RDY];
      st_reg.wp_d    <= CHPM_CTRL_RST[CHPM_CTRL_WP];
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Pin functions by mode
  // ****************************************
  // R13: shared pins follow the latched mode
  always_comb begin
    unique case (st_reg.mode)
      CHPM_MODE_IO: begin
        pin37_o  = st_reg.ctrl[CHPM_CTRL_IRQ] ? 1'b0 : 1'b1;
        pin42_o  = ~st_reg.ctrl[CHPM_CTRL_WAIT];
        p46_lvl  = ~st_reg.status_alert;
        // R7: audio, negated when absent
        p45_lvl  = CHPM_HAS_AUDIO ? ~st_reg.ctrl[CHPM_CTRL_AUDIO] : 1'b1;
        p45_od   = 1'b0;
        p46_od   = 1'b0;
        pin42_oe = 1'b1;
      end
      CHPM_MODE_IDE: begin
        pin37_o  = st_reg.ctrl[CHPM_CTRL_IRQ];
        // Ready line is open drain: only pulls low while waiting
        pin42_o  = 1'b0;
        pin42_oe = st_reg.ctrl[CHPM_CTRL_WAIT];
        // R8: pass diagnostic open drain, partner may pull too
        p46_lvl  = ~st_reg.ctrl[CHPM_CTRL_DIAG_LOW];
        // R12: drive active/slave present open drain
        p45_lvl  = ~st_reg.ctrl[CHPM_CTRL_ACT_LOW];
        p45_od   = 1'b1;
        p46_od   = 1'b1;
      end
      default: begin
        pin37_o  = st_reg.ctrl[CHPM_CTRL_RDY];
        pin42_o  = ~st_reg.ctrl[CHPM_CTRL_WAIT];
        pin42_oe = 1'b1;
        // R5: battery detects held high
        p45_lvl  = 1'b1;
        p46_lvl  = 1'b1;
        p45_od   = 1'b0;
        p46_od   = 1'b0;
      end
    endcase
  end

  assign p45_en = 1'b1;
  assign p46_en = 1'b1;

  chpm_ocpin u_pin45 (
    .drive_en   (p45_en),
    .open_drain (p45_od),
    .level      (p45_lvl),
    .pad_o      (pin45_o),
    .pad_oe     (pin45_oe)
  );

  chpm_ocpin u_pin46 (
    .drive_en   (p46_en),
    .open_drain (p46_od),
    .level      (p46_lvl),
    .pad_o      (pin46_o),
    .pad_oe     (pin46_oe)
  );

  // R9: no upper data byte used here, 8-bit hosts unaffected
  assign pin37_oe            = 1'b1;
  assign input_acknowledge_n = ~st_reg.ctrl[CHPM_CTRL_IN_ACK];
  assign reg_select          = st_reg.sel;
  assign attr_space          = st_reg.attr;
  assign is_master           = st_reg.master;
  assign s_awready           = ~st_reg.aw_got;
  assign s_wready            = ~st_reg.w_got;
  assign s_bvalid            = st_reg.bvalid;
  assign s_bresp             = st_reg.bresp;
  assign s_arready           = ~st_reg.rvalid;
  assign s_rvalid            = st_reg.rvalid;
  assign s_rdata             = st_reg.rdata;
  assign s_rresp             = st_reg.rresp;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_ide_mode;
    st_reg.mode == CHPM_MODE_IDE;
  endsequence

  // R5
  a_battery_high: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg.mode == CHPM_MODE_MEM |-> pin45_o && pin46_o && pin45_oe && pin46_oe)
    else $error("battery detect not high in memory mode");
  // R2
  a_taskfile_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ide_mode |=> reg_select[10:3] == 8'h00 && reg_select[2:0] == $past(host_addr[2:0]))
    else $error("task file decode wrong");
  // R1
  // Decode was cleared by reset on the cycle before release
  a_full_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg.mode != CHPM_MODE_IDE ##1 (st_reg.mode != CHPM_MODE_IDE && $past(aresetn))
      |-> reg_select == $past(host_addr) && attr_space == !$past(attr_select_n))
    else $error("memory or io decode wrong");
  // R6
  a_status_alert: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg.mode == CHPM_MODE_IO && st_reg.csr == 2'h3 |=> !pin46_o)
    else $error("status changed not asserted");
  // R14
  a_mode_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> $stable(st_reg.mode))
    else $error("mode changed outside reset");
  // R7
  a_audio_out: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg.mode == CHPM_MODE_IO |-> pin45_o == !st_reg.ctrl[CHPM_CTRL_AUDIO])
    else $error("audio level wrong");
  // R8
  a_diag_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ide_mode |-> !pin46_o && (pin46_oe == st_reg.ctrl[CHPM_CTRL_DIAG_LOW]))
    else $error("pass diagnostic drive wrong");
  // R12
  a_active_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ide_mode |-> !pin45_o && (pin45_oe == st_reg.ctrl[CHPM_CTRL_ACT_LOW]))
    else $error("drive active drive wrong");
  // R13
  a_pin37_map: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg.mode == CHPM_MODE_MEM |-> pin37_o == st_reg.ctrl[CHPM_CTRL_RDY])
    else $error("ready busy not on pin 37");
  // R11
  a_master_strap: assert property (@(posedge aclk)
    !aresetn |=> is_master == !$past(cable_select_n))
    else $error("master strap wrong");
endmodule // chpm_pin_map

// >>> hw/chpm_pkg.sv
// Constants for the card connector pin function map.
// Assumes one 125 MHz clock and an AXI4-Lite register port.
package chpm_pkg;
  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int          CHPM_AW           = 8;
  localparam logic [7:0]  CHPM_OFF_CTRL     = 8'h00;
  localparam logic [7:0]  CHPM_OFF_STATUS   = 8'h04;
  localparam logic [7:0]  CHPM_OFF_CSR      = 8'h08;
  localparam logic [7:0]  CHPM_OFF_ADDR     = 8'h0C;
  localparam logic [1:0]  CHPM_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  CHPM_RESP_SLVERR  = 2'h2;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CHPM_CTRL_MODE_LO  = 0;  // Mode requested for next reset
  localparam int CHPM_CTRL_RDY      = 2;  // Card ready (1) or busy (0)
  localparam int CHPM_CTRL_WP       = 3;  // Write protect
  localparam int CHPM_CTRL_IRQ      = 4;  // Interrupt request from function
  localparam int CHPM_CTRL_WAIT     = 5;  // Extend cycle (wait asserted)
  localparam int CHPM_CTRL_IN_ACK   = 6;
  localparam int CHPM_CTRL_AUDIO    = 7;  // Binary audio level
  localparam int CHPM_CTRL_DIAG_LOW = 8;  // Drive pass diagnostic low
  localparam int CHPM_CTRL_ACT_LOW  = 9;  // Drive active/slave present low
  localparam int CHPM_CSR_SIGCHG    = 0;  // Enable status changed output
  localparam int CHPM_CSR_CHANGED   = 1;  // Sticky change seen
  localparam logic [9:0] CHPM_CTRL_RST = 10'h004;
  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic [1:0] {
    CHPM_MODE_MEM = 2'h0,
    CHPM_MODE_IO  = 2'h1,
    CHPM_MODE_IDE = 2'h3
  } chpm_mode_t;
  localparam logic CHPM_HAS_IDE   = 1'b1;  // Storage-class card
  localparam logic CHPM_HAS_AUDIO = 1'b1;
endpackage

// >>> hw/chpm_ocpin.sv
// One two-way connector pin with push-pull or open-drain output.
// Assumes the pad combines enable and level outside.
`timescale 1ns/10ps
module chpm_ocpin (
  // Control
  input  wire logic drive_en,
  input  wire logic open_drain,
  input  wire logic level,
  // Pad
  output logic      pad_o,
  output logic      pad_oe
);
  // Open drain only pulls low; push-pull drives both levels
  always_comb begin
    pad_o  = open_drain ? 1'b0 : level;
    pad_oe = drive_en & (open_drain ? ~level : 1'b1);
  end
endmodule // chpm_ocpin

// >>> testbench/chpm_host_model.sv
// Host socket controller model facing the card pin map.
// Assumes the bench sets task_file whenever it changes the card mode.
`timescale 1ns/10ps
module chpm_host_model (
  // Bench side
  input  wire logic        task_file,
  input  wire logic [10:0] addr_req,
  input  wire logic        attr_req_n,
  input  wire logic        far_diag_low,
  input  wire logic        far_active_low,
  // Card side
  input  wire logic        pin45_o,
  input  wire logic        pin45_oe,
  input  wire logic        pin46_o,
  input  wire logic        pin46_oe,
  output logic [10:0]      host_addr,
  output logic             attr_select_n,
  output logic             pin45_i,
  output logic             pin46_i
);
  // ****************************************
  // Address side
  // ****************************************
  // upper lines grounded
  assign host_addr     = task_file ? {8'h00, addr_req[2:0]} : addr_req;
  assign attr_select_n = task_file | attr_req_n;
  // ****************************************
  // Shared handshake wires
  // ****************************************
  // wired-and handshake
  // Pull-up holds a released line high, never the last driven value
  assign pin45_i = (pin45_oe ? pin45_o : 1'b1) & ~(task_file & far_active_low);
  assign pin46_i = (pin46_oe ? pin46_o : 1'b1) & ~(task_file & far_diag_low);
endmodule // chpm_host_model

// >>> testbench/card_host_pin_function_map_test.sv
// Self-checking bench for the card connector pin map.
// Assumes chpm_host_model on the far side and one 125 MHz clock.
`timescale 1ns/10ps
module card_host_pin_function_map_test;
  import chpm_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready, attr_select_n, attr_req_n;
  logic        cable_select_n, task_file, far_diag_low, far_active_low, attr_space;
  logic        is_master, input_acknowledge_n, pin37_o, pin37_oe, pin42_o, pin42_oe;
  logic        pin45_i, pin45_o, pin45_oe, pin46_i, pin46_o, pin46_oe;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic [10:0] host_addr, addr_req, reg_select;
  logic [33:0] exp_q[$];
  int          failures, cmp_count, cycles, seed;

  chpm_pin_map dut_u (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .host_addr,
    .attr_select_n, .cable_select_n, .pin37_o, .pin37_oe, .pin42_o, .pin42_oe,
    .input_acknowledge_n, .pin45_i, .pin45_o, .pin45_oe, .pin46_i, .pin46_o,
    .pin46_oe, .reg_select, .attr_space, .is_master);
  chpm_host_model host_u (.task_file, .addr_req, .attr_req_n, .far_diag_low,
    .far_active_low, .pin45_o, .pin45_oe, .pin46_o, .pin46_oe, .host_addr,
    .attr_select_n, .pin45_i, .pin46_i);

  always #4 aclk = ~aclk;
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Read results and write responses are judged here, in issue order
  always @(posedge aclk) begin
    if (aresetn && s_rvalid && s_rready && exp_q.size() > 0)
      chk("read", {s_rresp, s_rdata}, exp_q.pop_front());
    if (aresetn && s_bvalid && s_bready && exp_q.size() > 0)
      chk("bresp", 34'(s_bresp), exp_q.pop_front());
  end

  // Run is far shorter than this; reaching it means a hang
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      failures = failures + 1;
      end_of_test();
    end
  end
  // ****************************************
  // Bus and pin tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic aw_done;
    logic w_done;
    @(posedge aclk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    aw_done = 1'b0;
    w_done  = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) begin
        aw_done = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_done = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    exp_q.push_back(34'(er));
    while (!s_bvalid) @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    exp_q.push_back(e);
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    while (!s_rvalid) @(posedge aclk);
  endtask

  task automatic pins(input logic [8:0] e);
    repeat (3) @(posedge aclk);
    chk("pins", 34'({input_acknowledge_n, pin37_o, pin37_oe, pin42_o, pin42_oe,
        pin45_o, pin45_oe, pin46_o, pin46_oe}), 34'(e));
  endtask

  // Exactly one reset edge, so the requested mode is the one latched
  task automatic mode_rst(input logic cs_n, input logic tf);
    @(posedge aclk);
    cable_select_n <= cs_n;
    task_file      <= tf;
    aresetn        <= 1'b0;
    @(posedge aclk);
    aresetn        <= 1'b1;
  endtask

  task automatic decode(input logic tf);
    logic [11:0] e;
    @(posedge aclk);
    addr_req   <= 11'($random(seed));
    attr_req_n <= 1'($random(seed));
    repeat (3) @(posedge aclk);
    e = tf ? {9'h000, addr_req[2:0]} : {!attr_req_n, addr_req};
    chk("decode", 34'({attr_space, reg_select}), 34'(e));
    rd(CHPM_OFF_ADDR, 34'(e));
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {aclk, aresetn, s_awvalid, s_wvalid, s_arvalid, task_file} = '0;
    {far_diag_low, far_active_low, s_awaddr, s_araddr, s_wdata, addr_req} = '0;
    {s_bready, s_rready, attr_req_n, cable_select_n} = 4'hF;
    s_wstrb   = 4'hF;
    failures  = 0;
    cmp_count = 0;
    cycles    = 0;
    seed      = 84;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CHPM_OFF_CTRL, 34'h004);
    rd(CHPM_OFF_CSR, 34'h000);
    rd(CHPM_OFF_STATUS, 34'h000);
    rd(8'h10, {CHPM_RESP_SLVERR, 32'h0});
    wr(8'h10, 32'h1, CHPM_RESP_SLVERR);
    pins(9'h1FF);
    wr(CHPM_OFF_CTRL, 32'h060);
    pins(9'h05F);
    rd(CHPM_OFF_CTRL, 34'h060);
    for (int i = 0; i < 3; i++) decode(1'b0);
    $display("Memory mode test done");
    wr(CHPM_OFF_CTRL, 32'h001);
    mode_rst(1'b1, 1'b0);
    rd(CHPM_OFF_STATUS, 34'h001);
    pins(9'h1FF);
    wr(CHPM_OFF_CTRL, 32'h00C);
    pins(9'h1FF);
    wr(CHPM_OFF_CSR, 32'h003);
    pins(9'h1FF);
    rd(CHPM_OFF_CSR, 34'h001);
    wr(CHPM_OFF_CTRL, 32'h008);
    pins(9'h1FD);
    rd(CHPM_OFF_CSR, 34'h003);
    wr(CHPM_OFF_CSR, 32'h003);
    pins(9'h1FF);
    wr(CHPM_OFF_CTRL, 32'h00B);
    rd(CHPM_OFF_STATUS, 34'h001);
    wr(CHPM_OFF_CTRL, 32'h0BB);
    pins(9'h157);
    $display("I/O mode test done");
    mode_rst(1'b0, 1'b1);
    @(posedge aclk);
    far_diag_low   <= 1'b1;
    far_active_low <= 1'b1;
    chk("master", 34'(is_master), 34'h1);
    pins(9'h140);
    rd(CHPM_OFF_STATUS, 34'h03B);
    @(posedge aclk);
    far_diag_low   <= 1'b0;
    far_active_low <= 1'b0;
    wr(CHPM_OFF_CTRL, 32'h330);
    pins(9'h1D5);
    for (int i = 0; i < 3; i++) decode(1'b1);
    wr(CHPM_OFF_CTRL, 32'h000);
    pins(9'h140);
    rd(CHPM_OFF_STATUS, 34'h00B);
    $display("Task-file mode test done");
    end_of_test();
  end
endmodule // card_host_pin_function_map_test
